//--- design/ms_timer.sv
/*
 * Down-counting delay timer driven by a one-cycle tick enable.
 * Assumes start is a pulse; done pulses once when the count is spent.
 */
`timescale 1ns/1ps
`default_nettype none
module ms_timer #(
	parameter int W = 24
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic start,
	input wire logic [W-1:0] count,
	output logic busy,
	output logic done
);
	logic [W-1:0] cnt_reg;

	// A zero count finishes on the next cycle, so no tick is waited for.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cnt_reg <= count;
				busy <= 1'b1;
			end else if (busy && cnt_reg == '0) begin
				busy <= 1'b0;
				done <= 1'b1;
			end else if (busy && tick) begin
				cnt_reg <= cnt_reg - W'(1);
			end
		end
	end
endmodule : ms_timer
`default_nettype wire

//--- design/output_sequencing_fault_manager.sv
/*
 * Output sequencing and fault manager: decides when the converter output
 * turns on and off, ramps its setpoint, handles tracking, warnings, faults,
 * delays and retries. Assumes all inputs are synchronous to mclk and that
 * configuration ports are held steady by the management logic.
 */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Output enable source: bus on command, enable pin, or both together.
// - Programmable ramp up, ramp down, turn-on delay and turn-off delay.
// - Start into pre-charged output from its level, rise time kept.
// - Disable ramps down to off target then tristates the driver.
// - Tracking is off after reset, enabled only by feature control.
// - With tracking, setpoint is the lower of programmed and tracking value.
// - Tracking enabled with zero tracking input never starts the output from off; a restart after the retry delay is not blocked.
// - Tracking overrides a non-zero off level during shutdown.
// - Sync pin is input or output by pin configuration; off after reset.
// - Warnings set flags and alert only; faults set flags and trigger response.
// - Alert assertion is maskable per class; one mask bit covers its warning and its fault.
// - Over-temperature fault ramps down softly to off target by default.
// - Other faults switch both power switches off, output high-impedance.
// - Non-zero fault delay: wait, recheck, respond only if persisting.
// - Non-zero retry delay: wait, restart; respond again if still present.
// - With non-zero fault delay, retry delay is one hundred times it.
// - Retry count zero to six; seven means unlimited hiccup.
// - Over-current uses the unfiltered fast current sample.
// - Inductor current is filtered and averaged for telemetry and limits.
// - Reports controller die temperature and power stage temperature.
// - By default pin must be high; bus command ignored.
// - Cycling the enable pin clears a latched-off fault.
module output_sequencing_fault_manager #(
	parameter int VW = 12,
	parameter int TW = 16,
	parameter int DW = 24,
	parameter int TICK_CYCLES = seq_pkg::TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic enable_pin,
	input wire logic bus_on,
	input wire logic [1:0] onoff_source,
	input wire logic [VW-1:0] vout_setting,
	input wire logic [VW-1:0] vout_off_target,
	input wire logic [VW-1:0] vout_sense,
	input wire logic [VW-1:0] rise_step,
	input wire logic [VW-1:0] fall_step,
	input wire logic [DW-1:0] on_delay_ms,
	input wire logic [DW-1:0] off_delay_ms,
	input wire logic feature_control_command,
	input wire logic [VW-1:0] tracking_voltage_input,
	input wire logic [1:0] pin_configuration_command,
	input wire logic [seq_pkg::NUM_FAULTS-1:0] warn_cond,
	input wire logic [seq_pkg::NUM_FAULTS-1:0] fault_cond_filt,
	input wire logic oc_fast_cond,
	input wire logic [seq_pkg::NUM_FAULTS-1:0] alert_mask,
	input wire logic [seq_pkg::NUM_FAULTS-1:0] soft_off_sel,
	input wire logic [TW-1:0] fault_delay_ms,
	input wire logic [TW-1:0] retry_delay_ms,
	input wire logic [2:0] retry_limit,
	input wire logic [TW-1:0] iout_raw,
	input wire logic [TW-1:0] temp_ctrl_raw,
	input wire logic [TW-1:0] temp_stage_raw,
	output logic [VW-1:0] setpoint,
	output logic driver_on,
	output logic driver_tristate,
	output logic sync_oe,
	output logic sync_is_input,
	output logic [seq_pkg::NUM_FAULTS-1:0] warn_flags,
	output logic [seq_pkg::NUM_FAULTS-1:0] fault_flags,
	output logic alert_n,
	output logic latched_off,
	output logic [TW-1:0] iout_avg,
	output logic [TW-1:0] temp_ctrl,
	output logic [TW-1:0] temp_stage
);
	typedef enum logic [6:0] {
		S_OFF = 7'h01,
		S_ON_DLY = 7'h02,
		S_RAMP_UP = 7'h04,
		S_RUN = 7'h08,
		S_OFF_DLY = 7'h10,
		S_RAMP_DN = 7'h20,
		S_RETRY = 7'h40
	} seq_state_t;

	localparam int NF = seq_pkg::NUM_FAULTS;

	seq_state_t state_reg, state_next;
	logic rst_s1_reg, rst_n;
	logic tick, tick_cnt_zero;
	logic [31:0] tick_cnt_reg;
	logic en_req, src_pin, src_bus;
	logic pin_prev_reg;
	logic [VW-1:0] eff_target, ramp_target, ramp_level;
	logic ramp_load, ramp_at, ramp_up_dir;
	logic [NF-1:0] fault_now, pend_reg;
	logic any_fault, soft_fault, confirm;
	logic [TW-1:0] fdly_cnt_reg;
	logic fdly_busy_reg;
	logic [2:0] retry_cnt_reg;
	logic dly_start, dly_done, dly_busy;
	logic [DW-1:0] dly_count, retry_dly;
	localparam int IAVG_W = seq_pkg::IAVG_SHIFT;
	logic [TW+IAVG_W-1:0] iacc_reg;
	logic ramp_step_en;

	// Reset release through two flops; assertion stays asynchronous.
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
		end
	end

	// Millisecond tick divider.
	assign tick_cnt_zero = (tick_cnt_reg == 32'h0);
	assign tick = tick_cnt_zero;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) tick_cnt_reg <= 32'h0;
		else tick_cnt_reg <= tick_cnt_zero ? 32'(TICK_CYCLES - 1) : tick_cnt_reg - 32'h1;
	end

	// Enable source decode; default is pin only with bus ignored.
	assign src_pin = (onoff_source == seq_pkg::SRC_PIN);
	assign src_bus = (onoff_source == seq_pkg::SRC_BUS);
	assign en_req = src_pin ? enable_pin : src_bus ? bus_on : (enable_pin && bus_on);

	// Tracking only when feature control sets it; lower value wins.
	assign eff_target = (feature_control_command && tracking_voltage_input < vout_setting)
		? tracking_voltage_input : vout_setting;
	// During shutdown tracking replaces the off target, still capped by the setting.
	assign ramp_target = (state_reg == S_RAMP_DN)
		? (feature_control_command ? eff_target : vout_off_target)
		: eff_target;
	assign ramp_up_dir = (state_reg == S_RAMP_UP) || (state_reg == S_RUN);
	// Start from the sensed output so a pre-charge is not pulled down.
	assign ramp_load = (state_reg == S_ON_DLY) && dly_done;
	// The ramp moves only while the driver runs, so an idle output keeps its last level.
	assign ramp_step_en = (state_reg inside {S_RAMP_UP, S_RUN, S_RAMP_DN});

	setpoint_ramp #(.W(VW)) u_ramp (
		.mclk(mclk),
		.rst_n(rst_n),
		.step_en(ramp_step_en),
		.load(ramp_load),
		.load_val(vout_sense),
		.target(ramp_target),
		.step(ramp_up_dir ? rise_step : fall_step),
		.level(ramp_level),
		.at_target(ramp_at)
	);

	// Fault sources: over-current from the fast unfiltered path.
	always_comb begin
		fault_now = fault_cond_filt;
		fault_now[seq_pkg::F_OC] = oc_fast_cond;
	end

	// Fault delay: pending detections rechecked when the delay expires.
	assign confirm = (fault_delay_ms == '0) ? 1'b1 : (fdly_busy_reg && fdly_cnt_reg == '0);
	assign any_fault = |((fault_delay_ms == '0 ? fault_now : pend_reg) & fault_now) && confirm;
	assign soft_fault = |(fault_now & soft_off_sel);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg <= '0;
			fdly_cnt_reg <= '0;
			fdly_busy_reg <= 1'b0;
		end else if (fdly_busy_reg) begin
			if (fdly_cnt_reg == '0) begin
				fdly_busy_reg <= 1'b0; // Detection dropped if condition gone.
				pend_reg <= '0;
			end else if (tick) fdly_cnt_reg <= fdly_cnt_reg - TW'(1);
		end else if (|fault_now && fault_delay_ms != '0) begin
			pend_reg <= fault_now;
			fdly_cnt_reg <= fault_delay_ms;
			fdly_busy_reg <= 1'b1;
		end
	end

	// Retry delay scaled from the fault delay when that is non-zero.
	assign retry_dly = (fault_delay_ms != '0)
		? DW'(fault_delay_ms * seq_pkg::RETRY_SCALE) : DW'(retry_delay_ms);
	assign dly_count = (state_next == S_ON_DLY) ? on_delay_ms
		: (state_next == S_OFF_DLY) ? off_delay_ms : retry_dly;
	assign dly_start = (state_next != state_reg) &&
		(state_next == S_ON_DLY || state_next == S_OFF_DLY || state_next == S_RETRY);

	ms_timer #(.W(DW)) u_timer (
		.mclk(mclk),
		.rst_n(rst_n),
		.tick(tick),
		.start(dly_start),
		.count(dly_count),
		.busy(dly_busy),
		.done(dly_done)
	);

	// Sequencer: off, on delay, ramp up, run, off delay, ramp down, retry.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_OFF: begin
				if (en_req && !latched_off && !(feature_control_command &&
					tracking_voltage_input == '0)) state_next = S_ON_DLY;
			end
			S_ON_DLY: begin
				if (any_fault) state_next = S_OFF;
				else if (!en_req) state_next = S_OFF;
				else if (dly_done) state_next = S_RAMP_UP;
			end
			S_RAMP_UP, S_RUN: begin
				if (any_fault && !soft_fault) state_next = S_RETRY;
				else if (any_fault) state_next = S_RAMP_DN;
				else if (!en_req) state_next = S_OFF_DLY;
				else if (ramp_at) state_next = S_RUN;
			end
			S_OFF_DLY: begin
				if (any_fault && !soft_fault) state_next = S_RETRY;
				else if (dly_done) state_next = S_RAMP_DN;
			end
			S_RAMP_DN: begin
				if (ramp_at) state_next = (|fault_flags) ? S_RETRY : S_OFF;
			end
			S_RETRY: begin
				if (latched_off) state_next = S_OFF;
				else if (dly_done) state_next = S_ON_DLY;
			end
			default: state_next = S_OFF;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) state_reg <= S_OFF;
		else state_reg <= state_next;
	end

	// Restart counting, latch-off at the limit, pin cycle clears the latch.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			retry_cnt_reg <= 3'h0;
			latched_off <= 1'b0;
			pin_prev_reg <= 1'b0;
		end else begin
			pin_prev_reg <= enable_pin;
			if (state_next == S_RETRY && state_reg != S_RETRY) begin
				if (retry_limit != seq_pkg::RETRY_UNLIMITED &&
					retry_cnt_reg >= retry_limit) latched_off <= 1'b1;
				else if (retry_limit != seq_pkg::RETRY_UNLIMITED)
					retry_cnt_reg <= retry_cnt_reg + 3'h1;
			end else if (enable_pin && !pin_prev_reg) begin
				latched_off <= 1'b0;
				retry_cnt_reg <= 3'h0;
			end else if (state_reg == S_RUN && !any_fault) begin
				retry_cnt_reg <= 3'h0;
			end
		end
	end

	// Flags: a confirmed fault (any_fault) sets its flag; a set flag clears once its live condition goes away.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			warn_flags <= '0;
			fault_flags <= '0;
			alert_n <= 1'b1;
		end else begin
			warn_flags <= warn_cond;
			fault_flags <= (fault_flags & fault_now) | (any_fault ? fault_now : '0);
			alert_n <= ~(|((warn_cond | fault_now) & ~alert_mask));
		end
	end

	// Driver and setpoint outputs registered; the start level goes out with the driver
	// so the first switching cycle never pulls a pre-charged output down.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			setpoint <= '0;
			driver_on <= 1'b0;
			driver_tristate <= 1'b1;
		end else begin
			setpoint <= ramp_load ? vout_sense : ramp_level;
			driver_on <= (state_next inside {S_RAMP_UP, S_RUN, S_OFF_DLY, S_RAMP_DN});
			driver_tristate <= !(state_next inside {S_RAMP_UP, S_RUN, S_OFF_DLY, S_RAMP_DN});
		end
	end

	// Sync pin mode; off after reset because both mode flops reset to off here.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync_oe <= 1'b0;
			sync_is_input <= 1'b0;
		end else begin
			sync_oe <= (pin_configuration_command == seq_pkg::SYNC_OUT);
			sync_is_input <= (pin_configuration_command == seq_pkg::SYNC_IN);
		end
	end

	// Exponential averaging of current; raw sample would be too noisy for limits.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			iacc_reg <= '0;
			iout_avg <= '0;
			temp_ctrl <= '0;
			temp_stage <= '0;
		end else begin
			iacc_reg <= iacc_reg - {{IAVG_W{1'b0}}, iacc_reg[TW+IAVG_W-1:IAVG_W]}
				+ {{IAVG_W{1'b0}}, iout_raw};
			iout_avg <= iacc_reg[TW+IAVG_W-1:IAVG_W];
			temp_ctrl <= temp_ctrl_raw;
			temp_stage <= temp_stage_raw;
		end
	end

	// Checks.
	property p_latch_blocks;
		@(posedge mclk) disable iff (!rst_n) latched_off && state_reg == S_OFF |=> state_reg == S_OFF;
	endproperty
	a_latch_blocks: assert property (p_latch_blocks) else $error("start while latched");

	property p_track_low;
		@(posedge mclk) disable iff (!rst_n)
		(state_reg == S_OFF && feature_control_command && tracking_voltage_input == '0)
		|=> state_reg == S_OFF;
	endproperty
	a_track_low: assert property (p_track_low) else $error("start with tracking low");

	property p_hard_off;
		@(posedge mclk) disable iff (!rst_n)
		(state_reg == S_RUN && any_fault && !soft_fault) |=> !driver_on && driver_tristate;
	endproperty
	a_hard_off: assert property (p_hard_off) else $error("hard fault left driver on");

	property p_soft_off;
		@(posedge mclk) disable iff (!rst_n)
		(state_reg == S_RUN && any_fault && soft_fault) |=> state_reg == S_RAMP_DN && driver_on;
	endproperty
	a_soft_off: assert property (p_soft_off) else $error("soft off not taken");

	property p_pin_default;
		@(posedge mclk) disable iff (!rst_n)
		(onoff_source == seq_pkg::SRC_PIN && !enable_pin && state_reg == S_OFF) |=> state_reg == S_OFF;
	endproperty
	a_pin_default: assert property (p_pin_default) else $error("started without pin");

	property p_sync_out;
		@(posedge mclk) disable iff (!rst_n)
		pin_configuration_command == seq_pkg::SYNC_OUT |=> sync_oe && !sync_is_input;
	endproperty
	a_sync_out: assert property (p_sync_out) else $error("sync mode wrong");

	property p_alert;
		@(posedge mclk) disable iff (!rst_n)
		|(warn_cond & ~alert_mask) |=> !alert_n;
	endproperty
	a_alert: assert property (p_alert) else $error("alert missing");

	property p_track_cap;
		@(posedge mclk) disable iff (!rst_n)
		(state_reg == S_RUN) |-> setpoint <= vout_setting;
	endproperty
	a_track_cap: assert property (p_track_cap) else $error("setpoint above setting");
endmodule : output_sequencing_fault_manager
`default_nettype wire

//--- design/seq_pkg.sv
/*
 * Shared constants for the output sequencing and fault manager: on/off source
 * encodings, fault class indices, reset values, pin modes and timing figures.
 * Assumes a single 40 MHz clock and one-cycle millisecond tick enables.
 */
package seq_pkg;
	// Clock and the millisecond tick derived from it.
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_TIME_NS = 1000000;
	localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
	// On/off source selection.
	localparam logic [1:0] SRC_PIN = 2'h0;
	localparam logic [1:0] SRC_BUS = 2'h1;
	localparam logic [1:0] SRC_BOTH = 2'h2;
	localparam logic [1:0] SRC_RESET = SRC_PIN;
	// Synchronisation pin modes.
	localparam logic [1:0] SYNC_OFF = 2'h0;
	localparam logic [1:0] SYNC_IN = 2'h1;
	localparam logic [1:0] SYNC_OUT = 2'h2;
	// Fault classes: output over/under voltage, input over/under voltage,
	// over-current, controller temperature, power stage temperature.
	localparam int NUM_FAULTS = 7;
	localparam int F_OC = 4;
	localparam int F_TCTRL = 5;
	localparam int F_TSTAGE = 6;
	// Retry field: values 0..6 are counts, 7 is unlimited.
	localparam logic [2:0] RETRY_UNLIMITED = 3'h7;
	localparam int RETRY_SCALE = 100;
	// Filter depth of the current averager as a shift.
	localparam int IAVG_SHIFT = 4;
endpackage : seq_pkg

//--- design/setpoint_ramp.sv
/*
 * Setpoint ramp generator: steps the reference toward a target by a fixed
 * step on each enable pulse. Assumes the step is derived from rise/fall time.
 */
`timescale 1ns/1ps
`default_nettype none
module setpoint_ramp #(
	parameter int W = 12
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic step_en,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic [W-1:0] target,
	input wire logic [W-1:0] step,
	output logic [W-1:0] level,
	output logic at_target
);
	logic [W:0] up_sum;
	logic [W-1:0] up_val;
	logic [W-1:0] dn_val;

	// Saturate so the ramp never overshoots the target.
	assign up_sum = {1'b0, level} + {1'b0, step};
	assign up_val = (up_sum > {1'b0, target}) ? target : up_sum[W-1:0];
	assign dn_val = ({1'b0, level} < ({1'b0, target} + {1'b0, step})) ? target : level - step;
	assign at_target = (level == target);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			level <= '0;
		end else if (load) begin
			level <= load_val;
		end else if (step_en && !at_target) begin
			level <= (level < target) ? up_val : dn_val;
		end
	end
endmodule : setpoint_ramp
`default_nettype wire

//--- tb/power_stage_model.sv
/*
 * Behavioural power stage seen from the sequencer: the sensed output follows
 * the setpoint while the driver runs and otherwise holds the pre-bias level.
 * Assumes the setpoint and driver flags come from the sequencer under test.
 */
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
	input wire logic driver_on,
	input wire logic [11:0] setpoint,
	input wire logic [11:0] prebias,
	output logic [11:0] vout_sense
);
	// A stopped stage never discharges a leaked-in voltage, so it reads pre-bias.
	assign vout_sense = driver_on ? setpoint : prebias;
endmodule : power_stage_model
`default_nettype wire

//--- tb/tb_output_sequencing_fault_manager.sv
/*
 * Self-checking bench for the output sequencing and fault manager.
 * Assumes a millisecond tick of four cycles so that delays stay short.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_output_sequencing_fault_manager;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic enable_pin = 1'b0, bus_on = 1'b0, feature_control_command = 1'b0, oc_fast_cond = 1'b0;
	logic [1:0] onoff_source = seq_pkg::SRC_PIN, pin_configuration_command = seq_pkg::SYNC_OFF;
	logic [11:0] vout_setting = 12'h200, vout_off_target = 12'h040, vout_sense;
	logic [11:0] rise_step = 12'h010, fall_step = 12'h008, tracking_voltage_input = 12'h000;
	logic [11:0] prebias = 12'h100;
	logic [23:0] on_delay_ms = 24'h000002, off_delay_ms = 24'h000001;
	logic [6:0] warn_cond = 7'h00, fault_cond_filt = 7'h00, alert_mask = 7'h00;
	logic [6:0] soft_off_sel = 7'h60;
	logic [15:0] fault_delay_ms = 16'h0000, retry_delay_ms = 16'h0000;
	logic [2:0] retry_limit = 3'h0;
	logic [15:0] iout_raw = 16'h0123, temp_ctrl_raw = 16'h0050, temp_stage_raw = 16'h0060;
	logic [11:0] setpoint;
	logic driver_on, driver_tristate, sync_oe, sync_is_input, alert_n, latched_off;
	logic [6:0] warn_flags, fault_flags;
	logic [15:0] iout_avg, temp_ctrl, temp_stage;
	logic [2:0] obs;
	int err_total = 0;
	int samples_checked = 0;

	// Free-running 40 MHz clock.
	always #12.5 mclk = ~mclk;

	assign obs = {latched_off, driver_tristate, driver_on};

	output_sequencing_fault_manager #(.TICK_CYCLES(4)) dut (
		.mclk(mclk), .rst_b(rst_b), .enable_pin(enable_pin), .bus_on(bus_on),
		.onoff_source(onoff_source), .vout_setting(vout_setting),
		.vout_off_target(vout_off_target), .vout_sense(vout_sense), .rise_step(rise_step),
		.fall_step(fall_step), .on_delay_ms(on_delay_ms), .off_delay_ms(off_delay_ms),
		.feature_control_command(feature_control_command),
		.tracking_voltage_input(tracking_voltage_input),
		.pin_configuration_command(pin_configuration_command), .warn_cond(warn_cond),
		.fault_cond_filt(fault_cond_filt), .oc_fast_cond(oc_fast_cond),
		.alert_mask(alert_mask), .soft_off_sel(soft_off_sel),
		.fault_delay_ms(fault_delay_ms), .retry_delay_ms(retry_delay_ms),
		.retry_limit(retry_limit), .iout_raw(iout_raw), .temp_ctrl_raw(temp_ctrl_raw),
		.temp_stage_raw(temp_stage_raw), .setpoint(setpoint), .driver_on(driver_on),
		.driver_tristate(driver_tristate), .sync_oe(sync_oe), .sync_is_input(sync_is_input),
		.warn_flags(warn_flags), .fault_flags(fault_flags), .alert_n(alert_n),
		.latched_off(latched_off), .iout_avg(iout_avg), .temp_ctrl(temp_ctrl),
		.temp_stage(temp_stage)
	);

	power_stage_model stage (
		.driver_on(driver_on), .setpoint(setpoint), .prebias(prebias),
		.vout_sense(vout_sense)
	);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Inputs always move the same 2 ns after the rising edge.
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : cyc

	// Bounded wait on one observed flag; a timeout shows up as a mismatch.
	task automatic wait_bit(input int idx, input logic v, input string what);
		int i;
		i = 0;
		while (obs[idx] !== v && i < 800) begin
			cyc(1);
			i++;
		end
		check(what, obs[idx], v);
	endtask : wait_bit

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task automatic t_reset;
		check("setpoint", setpoint, 16'h0000);
		check("tristate", driver_tristate, 1'b1);
		check("alert_n", alert_n, 1'b1);
		check("sync_oe", {sync_oe, sync_is_input}, 2'h0);
	endtask : t_reset

	// Pin start with a bus command present, pre-biased ramp, then ramp-down.
	task automatic t_pin_start_stop;
		bus_on = 1'b1;
		cyc(100);
		check("bus ignored", driver_on, 1'b0);
		enable_pin = 1'b1;
		wait_bit(0, 1'b1, "driver_on");
		check("no discharge", setpoint >= 12'h100, 1'b1);
		cyc(100);
		check("setpoint", setpoint, vout_setting);
		enable_pin = 1'b0;
		bus_on = 1'b0;
		wait_bit(1, 1'b1, "tristate");
		check("off level", setpoint, vout_off_target);
	endtask : t_pin_start_stop

	// Bus-only and both-together sources; a lone pin or lone bus must not start.
	task automatic t_sources;
		onoff_source = seq_pkg::SRC_BUS;
		enable_pin = 1'b1;
		cyc(100);
		check("pin ignored", driver_on, 1'b0);
		bus_on = 1'b1;
		wait_bit(0, 1'b1, "bus start");
		bus_on = 1'b0;
		wait_bit(1, 1'b1, "bus stop");
		onoff_source = seq_pkg::SRC_BOTH;
		enable_pin = 1'b0;
		bus_on = 1'b1;
		cyc(100);
		check("both needed", driver_on, 1'b0);
		enable_pin = 1'b1;
		wait_bit(0, 1'b1, "both start");
		cyc(100);
	endtask : t_sources

	// Warnings only flag and alert; the mask hides the alert.
	task automatic t_warn;
		warn_cond = 7'h01;
		cyc(10);
		check("warn flag", warn_flags[0], 1'b1);
		check("warn alert", alert_n, 1'b0);
		check("warn no action", driver_on, 1'b1);
		alert_mask = 7'h01;
		cyc(10);
		check("masked alert", alert_n, 1'b1);
		warn_cond = 7'h00;
		alert_mask = 7'h00;
		cyc(10);
		check("warn live", warn_flags, 7'h00);
	endtask : t_warn

	task automatic t_sync;
		pin_configuration_command = seq_pkg::SYNC_OUT;
		cyc(5);
		check("sync out", {sync_oe, sync_is_input}, 2'h2);
		pin_configuration_command = seq_pkg::SYNC_IN;
		cyc(5);
		check("sync in", {sync_oe, sync_is_input}, 2'h1);
		pin_configuration_command = seq_pkg::SYNC_OFF;
		cyc(5);
		check("sync off", {sync_oe, sync_is_input}, 2'h0);
	endtask : t_sync

	// Short glitch under a fault delay is dropped; the filtered over-current is not used.
	task automatic t_fault_delay;
		fault_delay_ms = 16'h0003;
		fault_cond_filt = 7'h01;
		cyc(2);
		fault_cond_filt = 7'h10;
		cyc(60);
		check("glitch dropped", obs, 3'h1);
		check("filtered oc unused", driver_on, 1'b1);
		fault_cond_filt = 7'h00;
		fault_delay_ms = 16'h0000;
		check("iout avg", iout_avg, iout_raw);
		check("temp ctrl", temp_ctrl, temp_ctrl_raw);
		check("temp stage", temp_stage, temp_stage_raw);
	endtask : t_fault_delay

	// Temperature fault ramps softly down before the driver floats.
	task automatic t_soft_off;
		fault_cond_filt = 7'h20;
		cyc(12);
		check("soft ramp driving", driver_tristate, 1'b0);
		check("soft ramp falling", setpoint < vout_setting, 1'b1);
		wait_bit(1, 1'b1, "soft end");
		check("soft off level", setpoint, vout_off_target);
		fault_cond_filt = 7'h00;
		enable_pin = 1'b0;
		cyc(20);
		enable_pin = 1'b1;
		wait_bit(0, 1'b1, "soft restart");
		cyc(100);
	endtask : t_soft_off

	// Fast over-current with no retries floats at once and latches until the pin cycles.
	task automatic t_hard_latch;
		oc_fast_cond = 1'b1;
		cyc(4);
		check("hard off", obs[1:0], 2'h2);
		check("oc flag", fault_flags[seq_pkg::F_OC], 1'b1);
		oc_fast_cond = 1'b0;
		wait_bit(2, 1'b1, "latched");
		cyc(100);
		check("stays off", driver_on, 1'b0);
		enable_pin = 1'b0;
		cyc(20);
		enable_pin = 1'b1;
		wait_bit(2, 1'b0, "latch cleared");
		wait_bit(0, 1'b1, "restart");
	endtask : t_hard_latch

	// Tracking: zero tracking input blocks start, a low one sets the level, setting caps it.
	task automatic t_tracking;
		enable_pin = 1'b0;
		wait_bit(1, 1'b1, "track prep off");
		feature_control_command = 1'b1;
		enable_pin = 1'b1;
		cyc(150);
		check("track blocks", driver_on, 1'b0);
		tracking_voltage_input = 12'h180;
		wait_bit(0, 1'b1, "track start");
		cyc(100);
		check("track level", setpoint, 12'h180);
		tracking_voltage_input = 12'h300;
		cyc(100);
		check("track cap", setpoint, vout_setting);
		tracking_voltage_input = 12'h000;
		enable_pin = 1'b0;
		wait_bit(1, 1'b1, "track stop");
		check("track off level", setpoint, 12'h000);
	endtask : t_tracking

	// Hiccup with unlimited retries; a fault delay makes the retry delay a hundred times the fault delay.
	task automatic t_retry;
		int n;
		feature_control_command = 1'b0;
		retry_limit = 3'h7;
		retry_delay_ms = 16'h0002;
		enable_pin = 1'b1;
		for (int k = 0; k < 2; k++) begin
			wait_bit(0, 1'b1, "retry run");
			oc_fast_cond = 1'b1;
			wait_bit(1, 1'b1, "retry off");
			oc_fast_cond = 1'b0;
			n = 0;
			while (driver_on !== 1'b1 && n < 800) begin
				cyc(1);
				n++;
			end
			check("restarted", driver_on, 1'b1);
			check("restart delay long", n > 300, k);
			check("hiccup no latch", latched_off, 1'b0);
			fault_delay_ms = 16'h0001;
		end
		fault_delay_ms = 16'h0000;
	endtask : t_retry

	// Watchdog, sized well above the sum of the scenarios.
	initial begin
		#(25 * 30000);
		err_total++;
		end_sim();
	end

	initial begin
		cyc(2);
		rst_b = 1'b1;
		cyc(3);
		t_reset();
		t_pin_start_stop();
		t_sources();
		t_warn();
		t_sync();
		t_fault_delay();
		t_soft_off();
		t_hard_latch();
		t_tracking();
		t_retry();
		end_sim();
	end
endmodule : tb_output_sequencing_fault_manager
`default_nettype wire
